// ---- rtl/fcd_pkg.sv ----
// Constants, types and field positions for the flash command decoder.
// Assumes a 22-bit word address, 16 partitions and 128 lock blocks.
// Overview of operation
// - FFh to a partition sets that partition to array reads.
// - 70h sets status reads; program or erase start does the same.
// - 90h sets identifier reads across all sixteen data lines.
// - 98h sets query reads on the low eight data lines.
// - Error bits 5,4,3,1 are cleared only by reset or by 50h.
// - Word program: setup 40h, then address and data write starts it.
// - Setup 10h acts exactly like 40h.
// - While busy, shown status refreshes only on chip or output enable fall.
// - 30h then D0h enters fast program; other commands then ignored.
// - Erase setup followed by anything but D0h sets bits 5:4, status reads.
// - Erase confirm address selects the block to erase.
// - While busy only read-status and suspend are accepted.
// - B0h suspends; sets bit 7 with bit 2 or bit 6.
// - Suspended state holds until resume or reset.
// - D0h while suspended resumes the operation.
// - Lock setup followed by an unknown code sets bits 5:4.
// - 60h then 01h locks the addressed block.
// - 60h then D0h unlocks, unless the block is locked down.
// - 60h then 2Fh places the addressed block in lock-down.
// - C0h then a write starts protection program or protection lock.
// - 60h then 03h loads read configuration from address bits 15:0.
// - After reset: array reads, status 80h, asynchronous page reads.
// - Any two-cycle setup write puts its partition in status reads; here setups are taken only while idle, not while busy or suspended.
package fcd_pkg;
    localparam int AW = 22;
    localparam int PART_LSB = 18;
    localparam int BLK_LSB = 15;
    localparam logic [7:0] C_ARRAY = 8'hFF, C_STATUS = 8'h70, C_IDENT = 8'h90;
    localparam logic [7:0] C_QUERY = 8'h98, C_CLEAR = 8'h50, C_PROG = 8'h40;
    localparam logic [7:0] C_PROG_ALT = 8'h10, C_EFP = 8'h30, C_ERASE = 8'h20;
    localparam logic [7:0] C_CONFIRM = 8'hD0, C_SUSPEND = 8'hB0;
    localparam logic [7:0] C_LOCKSET = 8'h60, C_LOCK = 8'h01, C_LOCKDN = 8'h2F;
    localparam logic [7:0] C_PROT = 8'hC0, C_SETRCR = 8'h03;
    localparam logic [15:0] PROT_LOCK_DATA = 16'hFFFD;
    localparam logic [7:0] SR_RESET = 8'h80;
    localparam logic [7:0] SR_STICKY = 8'h3A;
    localparam logic [7:0] SR_SEQERR = 8'h30;
    localparam int SR_READY = 7, SR_ESUSP = 6, SR_PSUSP = 2;
    localparam logic [15:0] RCR_RESET = 16'hFFFF;
    localparam logic [7:0] A_STATUS = 8'h00, A_MODES = 8'h04, A_RCR = 8'h08;
    localparam logic [7:0] A_OPADDR = 8'h0C, A_CTRL = 8'h10;
    localparam logic [7:0] A_LOCKSEL = 8'h14, A_LOCKST = 8'h18;
    localparam int CTRL_DONE = 0;
    typedef enum logic [1:0] {M_ARRAY, M_STATUS, M_IDENT, M_QUERY} fcd_mode_t;
    typedef enum logic [1:0] {OP_PROG, OP_EFP, OP_ERASE, OP_PROT} fcd_op_t;
    typedef enum logic [2:0] {
        D_IDLE, D_PROG, D_EFP_SET, D_EFP, D_ERASE, D_LOCK, D_PROTSET
    } fcd_dec_t;
    typedef enum logic [1:0] {W_IDLE, W_BUSY, W_SUSP} fcd_wsm_t;
endpackage : fcd_pkg

// ---- rtl/fcd_top.sv ----
// Command decoder with write state machine control for a partitioned flash.
// Assumes host writes on asynchronous pins, held for at least 4 clocks
// after the write strobe rises; software stands in for the algorithms
// over AHB-Lite and reports completion and errors there.
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fcd_top
    import fcd_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_reset,
    input  wire logic          i_ce_n,
    input  wire logic          i_oe_n,
    input  wire logic          i_we_n,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [15:0]   i_dq,
    input  wire logic          i_hsel,
    input  wire logic [31:0]   i_haddr,
    input  wire logic [1:0]    i_htrans,
    input  wire logic          i_hwrite,
    input  wire logic [2:0]    i_hsize,
    input  wire logic [31:0]   i_hwdata,
    input  wire logic          i_hready,
    output logic               o_hreadyout,
    output logic               o_hresp,
    output logic [31:0]        o_hrdata,
    output logic               o_wsm_start,
    output logic [1:0]         o_wsm_op,
    output logic [AW-1:0]      o_wsm_addr,
    output logic [15:0]        o_wsm_data,
    output logic               o_wsm_suspend,
    output logic               o_wsm_resume,
    output logic [31:0]        o_part_mode,
    output logic [7:0]         o_status_view,
    output logic [15:0]        o_rcr
);
    typedef struct packed {
        logic            we1, we2, we3, ce1, ce2, ce3, oe1, oe2, oe3;
        logic [AW-1:0]   a1, a2;
        logic [15:0]     d1, d2;
        fcd_dec_t        dec;
        fcd_wsm_t        write_state_machine;
        fcd_op_t         op;
        logic [31:0]     modes;
        logic [7:0]      sr, view;
        logic [15:0]     rcr;
        logic [127:0]    locked, lockdn;
        logic [6:0]      locksel;
        logic            start, susp, res;
        logic [AW-1:0]   waddr;
        logic [15:0]     wdata;
        logic            ph_wr;
        logic [7:0]      ph_addr;
        logic [31:0]     rdata;
    } fcd_state_t;

    fcd_state_t s_r, s_nxt;
    logic       w_ev;
    logic [7:0] cmd;
    logic [3:0] part;
    logic [6:0] blk;
    logic       ce_fall, oe_fall;
    logic       clr_ok;
    logic [7:0] sw_set;
    logic       sw_done;

    // Write taken on the rising edge of the synchronised write strobe
    assign w_ev    = s_r.we2 & ~s_r.we3 & ~s_r.ce3;
    assign cmd     = s_r.d2[7:0];
    assign part    = s_r.a2[AW-1:PART_LSB];
    assign blk     = s_r.a2[AW-1:BLK_LSB];
    assign ce_fall = s_r.ce3 & ~s_r.ce2;
    assign oe_fall = s_r.oe3 & ~s_r.oe2;
    assign sw_set  = (s_r.ph_wr && s_r.ph_addr == A_CTRL) ?
                     (i_hwdata[7:0] & SR_STICKY) : 8'h00;
    assign sw_done = s_r.ph_wr && s_r.ph_addr == A_CTRL && i_hwdata[CTRL_DONE];

    function automatic logic [31:0] set_mode(input logic [31:0] m,
                                             input logic [3:0] p,
                                             input fcd_mode_t v);
        logic [31:0] r;
        r = m;
        r[{p, 1'b0} +: 2] = v;
        return r;
    endfunction : set_mode

    function automatic logic is_setup(input logic [7:0] c);
        return c == C_PROG || c == C_PROG_ALT || c == C_EFP ||
               c == C_ERASE || c == C_LOCKSET || c == C_PROT;
    endfunction : is_setup

    always_comb begin
        s_nxt = s_r;
        clr_ok = 1'b0;
        s_nxt.we1 = i_we_n;
        s_nxt.we2 = s_r.we1;
        s_nxt.we3 = s_r.we2;
        s_nxt.ce1 = i_ce_n;
        s_nxt.ce2 = s_r.ce1;
        s_nxt.ce3 = s_r.ce2;
        s_nxt.oe1 = i_oe_n;
        s_nxt.oe2 = s_r.oe1;
        s_nxt.oe3 = s_r.oe2;
        s_nxt.a1 = i_addr;
        s_nxt.a2 = s_r.a1;
        s_nxt.d1 = i_dq;
        s_nxt.d2 = s_r.d1;
        s_nxt.start = 1'b0;
        s_nxt.susp = 1'b0;
        s_nxt.res = 1'b0;
        if (w_ev) begin
            case (s_r.dec)
                D_PROG, D_PROTSET: begin
                    s_nxt.start = 1'b1;
                    s_nxt.op = (s_r.dec == D_PROG) ? OP_PROG : OP_PROT;
                    s_nxt.waddr = s_r.a2;
                    s_nxt.wdata = s_r.d2;
                    s_nxt.write_state_machine = W_BUSY;
                    s_nxt.sr[SR_READY] = 1'b0;
                    s_nxt.modes = set_mode(s_r.modes, part, M_STATUS);
                    s_nxt.dec = D_IDLE;
                end
                D_EFP_SET: begin
                    if (cmd == C_CONFIRM) begin
                        s_nxt.dec = D_EFP;
                        s_nxt.op = OP_EFP;
                        s_nxt.waddr = s_r.a2;
                        s_nxt.write_state_machine = W_BUSY;
                        s_nxt.sr[SR_READY] = 1'b0;
                        s_nxt.modes = set_mode(s_r.modes, part, M_STATUS);
                    end else begin
                        s_nxt.sr = s_r.sr | SR_SEQERR;
                        s_nxt.dec = D_IDLE;
                    end
                end
                D_EFP: begin
                    // Every write is program data until software ends the mode
                    s_nxt.start = 1'b1;
                    s_nxt.op = OP_EFP;
                    s_nxt.waddr = s_r.a2;
                    s_nxt.wdata = s_r.d2;
                end
                D_ERASE: begin
                    if (cmd == C_CONFIRM) begin
                        s_nxt.start = 1'b1;
                        s_nxt.op = OP_ERASE;
                        s_nxt.waddr = s_r.a2;
                        s_nxt.wdata = s_r.d2;
                        s_nxt.write_state_machine = W_BUSY;
                        s_nxt.sr[SR_READY] = 1'b0;
                    end else begin
                        s_nxt.sr = s_r.sr | SR_SEQERR;
                    end
                    s_nxt.modes = set_mode(s_r.modes, part, M_STATUS);
                    s_nxt.dec = D_IDLE;
                end
                D_LOCK: begin
                    case (cmd)
                        C_LOCK: s_nxt.locked[blk] = 1'b1;
                        C_CONFIRM: begin
                            if (!s_r.lockdn[blk]) begin
                                s_nxt.locked[blk] = 1'b0;
                            end
                        end
                        C_LOCKDN: begin
                            s_nxt.locked[blk] = 1'b1;
                            s_nxt.lockdn[blk] = 1'b1;
                        end
                        C_SETRCR: begin
                            s_nxt.rcr = s_r.a2[15:0];
                            s_nxt.modes = set_mode(s_r.modes, part, M_ARRAY);
                        end
                        default: s_nxt.sr = s_r.sr | SR_SEQERR;
                    endcase
                    s_nxt.dec = D_IDLE;
                end
                default: begin
                    if (s_r.write_state_machine == W_BUSY) begin
                        // Busy: everything but status and suspend dropped
                        if (cmd == C_STATUS) begin
                            s_nxt.modes = set_mode(s_r.modes, part, M_STATUS);
                        end else if (cmd == C_SUSPEND) begin
                            s_nxt.write_state_machine = W_SUSP;
                            s_nxt.susp = 1'b1;
                            s_nxt.sr[SR_READY] = 1'b1;
                            if (s_r.op == OP_ERASE) begin
                                s_nxt.sr[SR_ESUSP] = 1'b1;
                            end else begin
                                s_nxt.sr[SR_PSUSP] = 1'b1;
                            end
                        end
                    end else begin
                        case (cmd)
                            C_ARRAY: s_nxt.modes =
                                set_mode(s_r.modes, part, M_ARRAY);
                            C_STATUS: s_nxt.modes =
                                set_mode(s_r.modes, part, M_STATUS);
                            C_IDENT: s_nxt.modes =
                                set_mode(s_r.modes, part, M_IDENT);
                            C_QUERY: s_nxt.modes =
                                set_mode(s_r.modes, part, M_QUERY);
                            C_CLEAR: clr_ok = 1'b1;
                            C_CONFIRM: begin
                                if (s_r.write_state_machine == W_SUSP) begin
                                    s_nxt.write_state_machine = W_BUSY;
                                    s_nxt.res = 1'b1;
                                    s_nxt.sr[SR_READY] = 1'b0;
                                    s_nxt.sr[SR_ESUSP] = 1'b0;
                                    s_nxt.sr[SR_PSUSP] = 1'b0;
                                end
                            end
                            default: begin
                                // Setups are refused while suspended
                                if (is_setup(cmd) && s_r.write_state_machine == W_IDLE) begin
                                    s_nxt.modes =
                                        set_mode(s_r.modes, part, M_STATUS);
                                    case (cmd)
                                        C_PROG, C_PROG_ALT:
                                            s_nxt.dec = D_PROG;
                                        C_EFP: s_nxt.dec = D_EFP_SET;
                                        C_ERASE: s_nxt.dec = D_ERASE;
                                        C_LOCKSET: s_nxt.dec = D_LOCK;
                                        default: s_nxt.dec = D_PROTSET;
                                    endcase
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
        if (clr_ok) begin
            s_nxt.sr = s_nxt.sr & ~SR_STICKY;
        end
        // Error reports from the algorithm beat a clear in the same cycle
        s_nxt.sr = s_nxt.sr | sw_set;
        if (sw_done && s_r.write_state_machine == W_BUSY) begin
            s_nxt.write_state_machine = W_IDLE;
            s_nxt.sr[SR_READY] = 1'b1;
            if (s_r.dec == D_EFP) begin
                s_nxt.dec = D_IDLE;
            end
        end
        // Shown status frozen between enable toggles while an op is live
        if (s_r.write_state_machine == W_IDLE || ce_fall || oe_fall) begin
            s_nxt.view = s_r.sr;
        end
        s_nxt.ph_wr = 1'b0;
        if (s_r.ph_wr && s_r.ph_addr == A_LOCKSEL) begin
            s_nxt.locksel = i_hwdata[6:0];
        end
        if (i_hsel && i_htrans[1] && i_hready) begin
            s_nxt.ph_wr = i_hwrite;
            s_nxt.ph_addr = i_haddr[7:0];
            case (i_haddr[7:0])
                A_STATUS: s_nxt.rdata = {22'h0, s_r.write_state_machine, s_r.sr};
                A_MODES: s_nxt.rdata = s_r.modes;
                A_RCR: s_nxt.rdata = {16'h0, s_r.rcr};
                A_OPADDR: s_nxt.rdata = {8'h0, s_r.op, s_r.waddr};
                A_LOCKSEL: s_nxt.rdata = {25'h0, s_r.locksel};
                A_LOCKST: s_nxt.rdata = {30'h0, s_r.lockdn[s_r.locksel],
                                         s_r.locked[s_r.locksel]};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
            s_r.we1 <= 1'b1;
            s_r.we2 <= 1'b1;
            s_r.we3 <= 1'b1;
            s_r.ce1 <= 1'b1;
            s_r.ce2 <= 1'b1;
            s_r.ce3 <= 1'b1;
            s_r.oe1 <= 1'b1;
            s_r.oe2 <= 1'b1;
            s_r.oe3 <= 1'b1;
            s_r.dec <= D_IDLE;
            s_r.write_state_machine <= W_IDLE;
            s_r.modes <= '0;
            s_r.sr <= SR_RESET;
            s_r.view <= SR_RESET;
            s_r.rcr <= RCR_RESET;
            s_r.locked <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_hreadyout   = 1'b1;
    assign o_hresp       = 1'b0;
    assign o_hrdata      = s_r.rdata;
    assign o_wsm_start   = s_r.start;
    assign o_wsm_op      = s_r.op;
    assign o_wsm_addr    = s_r.waddr;
    assign o_wsm_data    = s_r.wdata;
    assign o_wsm_suspend = s_r.susp;
    assign o_wsm_resume  = s_r.res;
    assign o_part_mode   = s_r.modes;
    assign o_status_view = s_r.view;
    assign o_rcr         = s_r.rcr;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_array_cmd: assert property (w_ev && s_r.dec == D_IDLE &&
        s_r.write_state_machine == W_IDLE && cmd == C_ARRAY |=> s_r.modes[{$past(part), 1'b0}
        +: 2] == M_ARRAY) else $error("array command ignored");
    a_status_cmd: assert property (w_ev && s_r.dec == D_IDLE &&
        s_r.write_state_machine != W_SUSP && cmd == C_STATUS |=> s_r.modes[{$past(part),
        1'b0} +: 2] == M_STATUS) else $error("status command ignored");
    a_sticky_hold: assert property (!clr_ok |=>
        (($past(s_r.sr) & SR_STICKY & ~s_r.sr) == 8'h00))
        else $error("error bit dropped without clear");
    a_prog_start: assert property (w_ev && s_r.dec == D_PROG |=>
        o_wsm_start && o_wsm_op == OP_PROG && o_wsm_addr == $past(s_r.a2)
        ##1 !o_wsm_start) else $error("program did not start once");
    a_alt_setup: assert property (w_ev && s_r.dec == D_IDLE &&
        s_r.write_state_machine == W_IDLE && cmd == C_PROG_ALT |=> s_r.dec == D_PROG)
        else $error("alternate setup not decoded");
    a_view_frozen: assert property (s_r.write_state_machine == W_BUSY && !ce_fall &&
        !oe_fall |=> $stable(o_status_view))
        else $error("status view moved without toggle");
    a_erase_seqerr: assert property (w_ev && s_r.dec == D_ERASE &&
        cmd != C_CONFIRM |=> s_r.sr[5:4] == 2'b11 && !o_wsm_start)
        else $error("erase sequence error not flagged");
    a_busy_ignore: assert property (w_ev && s_r.dec == D_IDLE &&
        s_r.write_state_machine == W_BUSY && cmd == C_ARRAY |=> $stable(s_r.modes))
        else $error("command accepted while busy");
    a_suspend_flags: assert property (w_ev && s_r.dec == D_IDLE &&
        s_r.write_state_machine == W_BUSY && cmd == C_SUSPEND |=> s_r.sr[SR_READY] &&
        (s_r.sr[SR_ESUSP] || s_r.sr[SR_PSUSP]) && o_wsm_suspend)
        else $error("suspend not reported");
    a_suspend_stays: assert property (s_r.write_state_machine == W_SUSP &&
        !(w_ev && s_r.dec == D_IDLE && cmd == C_CONFIRM) |=> s_r.write_state_machine == W_SUSP)
        else $error("left suspend without resume");
    a_lockdown_kept: assert property (w_ev && s_r.dec == D_LOCK &&
        cmd == C_CONFIRM && s_r.lockdn[blk] |=> s_r.locked[$past(blk)])
        else $error("locked-down block unlocked");

    c_prog: cover property (s_r.dec == D_PROG ##[1:50] o_wsm_start);
    c_suspend: cover property (o_wsm_suspend ##[1:200] o_wsm_resume);
    c_seqerr: cover property (s_r.dec == D_ERASE ##1 s_r.sr[5:4] == 2'b11);
    c_rcr: cover property (s_r.dec == D_LOCK ##1 $changed(o_rcr));
endmodule : fcd_top

// ---- sim/fcd_host_model.sv ----
// Host pin driver for the flash command decoder: one command write per call.
// Assumes the decoder samples pins through a two-flop synchroniser.
`timescale 1ns/1ps
module fcd_host_model
    import fcd_pkg::*;
(
    input  wire logic          i_clk,
    output logic               o_ce_n,
    output logic               o_oe_n,
    output logic               o_we_n,
    output logic [AW-1:0]      o_addr,
    output logic [15:0]        o_dq
);
    initial begin
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_addr = '0;
        o_dq   = '0;
    end
    // Strobe low and high long enough for the sync delay; lines held after
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_ce_n <= 1'b0;
        o_addr <= a;
        o_dq   <= d;
        repeat (3) @(posedge i_clk);
        o_we_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_we_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        o_ce_n <= 1'b1;
        // Released lines must not keep showing the last value
        o_addr <= ~a;
        o_dq   <= ~d;
        repeat (3) @(posedge i_clk);
    endtask : wr
    task automatic pulse_oe();
        @(posedge i_clk);
        o_oe_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        o_oe_n <= 1'b1;
        repeat (5) @(posedge i_clk);
    endtask : pulse_oe
endmodule : fcd_host_model

// ---- sim/flash_command_decoder_tb_top.sv ----
// Self-checking bench: pin host model plus AHB-Lite master, against a model.
// Assumes zero-wait AHB slave and pin effects within a write's span.
`timescale 1ns/1ps
module flash_command_decoder_tb_top;
    import fcd_pkg::*;
    logic          clk, rst, ce_n, oe_n, we_n, hsel, hwr, hro, st, sus, res;
    logic          hrsp;
    logic [AW-1:0] addr, waddr, a;
    logic [15:0]   dq, wdat, rcr, m_rcr;
    logic [31:0]   haddr, hwdata, hrdata, pmode, m_mode, rd;
    logic [1:0]    htrans, wop, m_lk [128];
    logic [7:0]    view, m_sr, m_dec, v0;
    logic [39:0]   q_exp [$], q_got [$];
    int num_errors, samples_checked, m_wsm, m_op, m_sus, m_res, g_sus, g_res;
    int m_efp;
    int k;
    always #5 clk = ~clk;
    fcd_host_model u_fcd_host_model (.i_clk(clk), .o_ce_n(ce_n),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_dq(dq));
    fcd_top u_fcd_top (.i_clk(clk), .i_reset(rst), .i_ce_n(ce_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr), .i_dq(dq), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwr),
        .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hro),
        .o_hreadyout(hro), .o_hresp(hrsp), .o_hrdata(hrdata), .o_wsm_start(st),
        .o_wsm_op(wop), .o_wsm_addr(waddr), .o_wsm_data(wdat),
        .o_wsm_suspend(sus), .o_wsm_resume(res), .o_part_mode(pmode),
        .o_status_view(view), .o_rcr(rcr));
    always @(posedge clk) begin
        if (st === 1'b1) q_got.push_back({wop, waddr, wdat});
        if (sus === 1'b1) g_sus++;
        if (res === 1'b1) g_res++;
    end
    task automatic cmp(input string n, input logic [39:0] e, logic [39:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic ahb(input logic w, input logic [7:0] ad, logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwr    <= w;
        haddr  <= {24'h0, ad};
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb
    task automatic chk();
        ahb(1'b0, A_STATUS, 32'h0);
        cmp("status", {m_wsm[1:0], m_sr}, rd[9:0]);
        cmp("hresp", 0, hrsp);
        cmp("modes", m_mode, pmode);
        cmp("rcr", m_rcr, rcr);
        cmp("suspends", m_sus, g_sus);
        cmp("resumes", m_res, g_res);
        cmp("starts", q_exp.size(), q_got.size());
        while (q_got.size() > 0 && q_exp.size() > 0)
            cmp("start", q_exp.pop_front(), q_got.pop_front());
    endtask : chk
    task automatic start(input int op, input logic [AW-1:0] wa, logic [15:0] d);
        q_exp.push_back({op[1:0], wa, d});
        m_wsm = 1;
        m_op  = op;
        m_sr[7] = 1'b0;
        m_mode[2*wa[21:18] +: 2] = 2'd1;
    endtask : start
    task automatic mw(input logic [AW-1:0] wa, input logic [15:0] d);
        int p;
        logic [7:0] c;
        p = wa[21:18];
        c = d[7:0];
        k = wa[21:15];
        u_fcd_host_model.wr(wa, d);
        // Fast program: every write is data until software ends the mode
        if (m_efp != 0) start(1, wa, d);
        else if (m_wsm == 1) begin
            if (c == 8'h70) m_mode[2*p +: 2] = 2'd1;
            if (c == 8'hB0) begin
                m_wsm = 2;
                m_sus++;
                m_sr |= (m_op == 2) ? 8'hC0 : 8'h84;
            end
        end else if (m_dec != 0) begin
            if (m_dec == 8'h40 || m_dec == 8'h10) start(0, wa, d);
            else if (m_dec == 8'hC0) start(3, wa, d);
            else if (m_dec == 8'h20 && c == 8'hD0) start(2, wa, d);
            else if (m_dec == 8'h30 && c == 8'hD0) begin
                m_efp = 1;
                m_wsm = 1;
                m_op  = 1;
                m_sr[7] = 1'b0;
                m_mode[2*p +: 2] = 2'd1;
            end
            else if (m_dec == 8'h60 && c == 8'h01) m_lk[k][0] = 1'b1;
            else if (m_dec == 8'h60 && c == 8'hD0)
                m_lk[k][0] = m_lk[k][1];
            else if (m_dec == 8'h60 && c == 8'h2F) m_lk[k][1] = 1'b1;
            else if (m_dec == 8'h60 && c == 8'h03) begin
                m_rcr = wa[15:0];
                m_mode[2*p +: 2] = 2'd0;
            end else m_sr |= 8'h30;
            m_dec = 0;
        end else case (c)
            8'hFF: m_mode[2*p +: 2] = 2'd0;
            8'h70: m_mode[2*p +: 2] = 2'd1;
            8'h90: m_mode[2*p +: 2] = 2'd2;
            8'h98: m_mode[2*p +: 2] = 2'd3;
            8'h50: m_sr &= ~8'h3A;
            8'h40, 8'h10, 8'h20, 8'h60, 8'hC0, 8'h30: if (m_wsm == 0) begin
                m_dec = c;
                m_mode[2*p +: 2] = 2'd1;
            end
            8'hD0: if (m_wsm == 2) begin
                m_wsm = 1;
                m_res++;
                m_sr &= ~8'hC4;
            end
            default: ;
        endcase
        chk();
    endtask : mw
    task automatic sw(input logic [7:0] v);
        ahb(1'b1, A_CTRL, {24'h0, v});
        m_sr |= v & 8'h3A;
        if (v[0] && m_wsm == 1) begin
            m_wsm = 0;
            m_efp = 0;
            m_sr[7] = 1'b1;
        end
        chk();
    endtask : sw
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        #500000;
        num_errors++;
        close_out();
    end
    initial begin
        logic [7:0] cd [5] = '{8'hFF, 8'h70, 8'h90, 8'h98, 8'h55};
        logic [7:0] lc [4] = '{8'hD0, 8'h01, 8'h2F, 8'hD0};
        logic [7:0] sq [3] = '{8'h20, 8'h60, 8'h30};
        clk = 0; rst = 1; hsel = 0; htrans = 0; hwr = 0; haddr = 0; hwdata = 0;
        m_mode = 0; m_sr = 8'h80; m_rcr = 16'hFFFF; m_dec = 0; m_wsm = 0;
        m_efp = 0;
        foreach (m_lk[i]) m_lk[i] = 2'b01;
        void'($urandom(32295));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk();
        cmp("view", 8'h80, view);
        ahb(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h0, rd);
        for (int i = 0; i < 15; i++)
            mw(AW'($urandom), {8'($urandom), cd[i % 5]});
        for (int i = 0; i < 2; i++) begin
            a = AW'($urandom);
            mw(a, i ? 16'h0010 : 16'h0040);
            mw(a, 16'($urandom));
            mw(a ^ 22'h040000, 16'h00FF);
            mw(a, 16'h0070);
            mw(AW'($urandom), 16'h00B0);
            mw(a, 16'h0040);
            mw(AW'($urandom), 16'h00D0);
            sw(8'h01);
        end
        a = AW'($urandom);
        mw(a, 16'h0020);
        mw(a ^ 22'h008000, 16'h00D0);
        mw(AW'($urandom), 16'h00B0);
        mw(AW'($urandom), 16'h00D0);
        sw(8'h01);
        foreach (sq[i]) begin
            a = AW'($urandom);
            mw(a, {8'h0, sq[i]});
            mw(a, 16'h0055);
            mw(AW'($urandom), 16'h0050);
        end
        a = AW'($urandom);
        mw(a, 16'h0030);
        mw(a, 16'h00D0);
        mw(a, 16'($urandom));
        mw(a ^ 22'h000001, 16'h00FF);
        sw(8'h01);
        sw(8'h3A);
        mw(AW'($urandom), 16'h00FF);
        mw(AW'($urandom), 16'h0050);
        a = AW'($urandom);
        foreach (lc[i]) begin
            mw(a, 16'h0060);
            mw(a, {8'h0, lc[i]});
            ahb(1'b1, A_LOCKSEL, k);
            ahb(1'b0, A_LOCKST, 32'h0);
            cmp("lock", m_lk[k], rd[1:0]);
        end
        a = AW'($urandom);
        mw(a, 16'h0060);
        mw(a, 16'h0003);
        mw(a, 16'h00C0);
        mw(a, 16'($urandom));
        sw(8'h01);
        a = AW'($urandom);
        mw(a, 16'h0040);
        v0 = m_sr;
        mw(a, 16'($urandom));
        sw(8'h08);
        cmp("view", v0, view);
        u_fcd_host_model.pulse_oe();
        cmp("view", m_sr, view);
        sw(8'h01);
        mw(a, 16'h0050);
        close_out();
    end
endmodule : flash_command_decoder_tb_top
